// file: rtl/sfsp_core.sv
// short floor speed profile sequencer for a lift drive
// assumes settings are static during a run and come from logic on mclk;
// command pins arrive asynchronously and are synchronised here
//
// Contract
// - leveling request before nominal speed is reached means short floor travel
// - simple mode above 40 %: slow to 40 %, hold, slow to leveling, stop
// - simple mode below 40 %: speed up to 40 %, hold, slow to leveling
// - simple mode, constant speed under 40 %: hold present speed for a time
// - simple mode, constant speed 40 % to nominal: slow to 40 %, hold, level
// - advanced mode computes optimal speed from reference, both gains, minimum time; the code uses nom_speed and the gain average only
// - advanced mode below optimal: speed up to it, hold minimum time
// - advanced mode beyond optimal: hold reached speed, then slow to leveling
// - simple, multi-speed priority: short floor nominal setting, leveling detection on
// - simple, dedicated inputs: nominal setting, no leveling detection
// - advanced, multi-speed: start reference as nominal, threshold detects leveling
// - advanced, dedicated inputs: nominal setting used for the pattern
// - optimal speed ignores s-curves; only the gains compensate them
// - multi-speed priority: leveling released in short floor returns to reference
// - dwell still runs in short floor but stays out of the calculation
// - no advanced short floor during rescue or inspection runs
// - ramp times are full scale travel of maximum output frequency
// - four ramp time pairs, chosen by inputs or automatic speed switchover
// - both distance gains reset to 150.0 % on factory initialisation
`timescale 1ns/1ns
`default_nettype none
module sfsp_core #(
  parameter int TICK_CYCLES = sfsp_pkg::TICK_CYCLES,
  parameter int SPD_W       = sfsp_pkg::SPD_W,
  parameter int TIME_W      = sfsp_pkg::TIME_W,
  parameter int GAIN_W      = sfsp_pkg::GAIN_W
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // command pins, asynchronous
  input  wire logic              run_cmd,
  input  wire logic              leveling_cmd,
  input  wire logic [1:0]        accel_decel_sel,
  input  wire logic              rescue_run,
  input  wire logic              inspection_run,
  input  wire logic              factory_init,
  input  wire logic              dwell_enable,
  // settings, same clock domain
  input  wire logic [1:0]        short_floor_mode_sel,
  input  wire logic [1:0]        speed_ref_priority_sel,
  input  wire logic [SPD_W-1:0]  speed_ref,
  input  wire logic [SPD_W-1:0]  leveling_speed,
  input  wire logic [SPD_W-1:0]  nominal_speed_setting,
  input  wire logic [SPD_W-1:0]  short_floor_nominal_speed,
  input  wire logic [SPD_W-1:0]  level_speed_detect_threshold,
  input  wire logic [SPD_W-1:0]  max_output_frequency,
  input  wire logic [TIME_W-1:0] min_constant_speed_time,
  input  wire logic              gain_load,
  input  wire logic [GAIN_W-1:0] accel_distance_gain,
  input  wire logic [GAIN_W-1:0] decel_distance_gain,
  input  wire logic [TIME_W-1:0] accel_time_1,
  input  wire logic [TIME_W-1:0] decel_time_1,
  input  wire logic [TIME_W-1:0] accel_time_2,
  input  wire logic [TIME_W-1:0] decel_time_2,
  input  wire logic [TIME_W-1:0] accel_time_3,
  input  wire logic [TIME_W-1:0] decel_time_3,
  input  wire logic [TIME_W-1:0] accel_time_4,
  input  wire logic [TIME_W-1:0] decel_time_4,
  input  wire logic [SPD_W-1:0]  decel_switch_freq,
  input  wire logic [SPD_W-1:0]  dwell_speed,
  input  wire logic [TIME_W-1:0] dwell_time,
  // status
  output logic [SPD_W-1:0]       speed_out,
  output logic                   short_floor_active,
  output logic                   level_detect_used,
  output logic                   hold_active,
  output logic [GAIN_W-1:0]      accel_gain_active,
  output logic [GAIN_W-1:0]      decel_gain_active
);
  logic [sfsp_pkg::SYN_W-1:0] syn1_reg;
  logic [sfsp_pkg::SYN_W-1:0] syn2_reg;
  logic                       run_s;
  logic                       lvl_s;
  logic [1:0]                 sel_s;
  logic                       resc_s;
  logic                       insp_s;
  logic                       finit_s;
  logic                       dwell_s;

  sfsp_pkg::sfsp_state_e state_reg;
  sfsp_pkg::sfsp_state_e state_next;

  logic [SPD_W-1:0]  speed_reg;
  logic [SPD_W-1:0]  start_ref_reg;
  logic [SPD_W-1:0]  sf_target_reg;
  logic [SPD_W-1:0]  sf_target_calc;
  logic [SPD_W-1:0]  target_speed;
  logic [SPD_W-1:0]  nom_speed;
  logic [SPD_W-1:0]  forty_speed;
  logic [SPD_W-1:0]  opt_speed;
  logic [31:0]       opt_raw;
  logic [GAIN_W:0]   avg_gain;
  logic [GAIN_W-1:0] accel_gain_reg;
  logic [GAIN_W-1:0] decel_gain_reg;
  logic [31:0]       hold_cnt_reg;
  logic [31:0]       hold_load_val;
  logic              prio_multi;
  logic              lvl_req;
  logic              sf_allowed;
  logic              adv_ok;
  logic              at_const;
  logic              reached;
  logic [TIME_W-1:0] accel_tbl [4];
  logic [TIME_W-1:0] decel_tbl [4];
  logic [TIME_W-1:0] accel_time;
  logic [TIME_W-1:0] decel_time;
  logic              tick_ms;
  logic              step_up;
  logic              step_dn;

  // two flip-flops on every asynchronous command pin
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syn1_reg <= '0;
      syn2_reg <= '0;
    end
    else
    begin
      syn1_reg <= {dwell_enable, factory_init, inspection_run, rescue_run,
                   accel_decel_sel, leveling_cmd, run_cmd};
      syn2_reg <= syn1_reg;
    end
  end

  assign run_s   = syn2_reg[sfsp_pkg::SYN_RUN];
  assign lvl_s   = syn2_reg[sfsp_pkg::SYN_LVL];
  assign sel_s   = syn2_reg[sfsp_pkg::SYN_SEL1:sfsp_pkg::SYN_SEL0];
  assign resc_s  = syn2_reg[sfsp_pkg::SYN_RESC];
  assign insp_s  = syn2_reg[sfsp_pkg::SYN_INSP];
  assign finit_s = syn2_reg[sfsp_pkg::SYN_FINIT];
  assign dwell_s = syn2_reg[sfsp_pkg::SYN_DWELL];

  // four ramp pairs; automatic switchover only moves the deceleration time
  assign accel_tbl = '{accel_time_1, accel_time_2, accel_time_3, accel_time_4};
  assign decel_tbl = '{decel_time_1, decel_time_2, decel_time_3, decel_time_4};

  always_comb
  begin
    accel_time = accel_tbl[sel_s];
    if (decel_switch_freq != '0)
      decel_time = (speed_reg >= decel_switch_freq) ? decel_tbl[0] : decel_tbl[3];
    else
      decel_time = decel_tbl[sel_s];
  end

  // nominal speed source and leveling detection by priority and mode
  always_comb
  begin
    prio_multi = (speed_ref_priority_sel == sfsp_pkg::PRIO_MULTI_A) ||
                 (speed_ref_priority_sel == sfsp_pkg::PRIO_MULTI_B);
    if (short_floor_mode_sel == sfsp_pkg::MODE_ADV)
      nom_speed = prio_multi ? start_ref_reg : nominal_speed_setting;
    else
      nom_speed = prio_multi ? short_floor_nominal_speed : nominal_speed_setting;
    // threshold detection counts only with multi-speed inputs and a short floor mode
    lvl_req = lvl_s || (prio_multi && (short_floor_mode_sel != sfsp_pkg::MODE_OFF) &&
              (level_speed_detect_threshold != '0) &&
              (speed_ref <= level_speed_detect_threshold));
    adv_ok     = (short_floor_mode_sel == sfsp_pkg::MODE_ADV) && !resc_s && !insp_s;
    sf_allowed = (short_floor_mode_sel == sfsp_pkg::MODE_SIMPLE) || adv_ok;
  end

  // targets of the two short floor methods
  always_comb
  begin
    forty_speed = SPD_W'((32'(nom_speed) * 32'(sfsp_pkg::PCT_SIMPLE)) /
                         32'(sfsp_pkg::PCT_FULL));
    // gains alone stand in for the s-curves and the dwell; higher gain, lower speed
    avg_gain = (GAIN_W+1)'(({1'b0, accel_gain_reg} + {1'b0, decel_gain_reg}) >> 1);
    if (avg_gain == '0)
      opt_raw = 32'(nom_speed);
    else
      opt_raw = (32'(nom_speed) * 32'(sfsp_pkg::GAIN_UNITY)) / 32'(avg_gain);
    opt_speed = (opt_raw > 32'(nom_speed)) ? nom_speed : SPD_W'(opt_raw);
    at_const  = (speed_reg == speed_ref);
    if (adv_ok)
      sf_target_calc = (speed_reg < opt_speed) ? opt_speed : speed_reg;
    else if (at_const && (speed_ref < forty_speed))
      sf_target_calc = speed_reg;
    else
      sf_target_calc = forty_speed;
  end

  // speed the ramp is heading for in each state
  always_comb
  begin
    unique case (state_reg)
      sfsp_pkg::SFSP_IDLE:       target_speed = '0;
      sfsp_pkg::SFSP_DWELL:      target_speed = dwell_speed;
      sfsp_pkg::SFSP_DWELL_HOLD: target_speed = speed_reg;
      sfsp_pkg::SFSP_RUN:        target_speed = speed_ref;
      sfsp_pkg::SFSP_SF_RAMP:    target_speed = sf_target_reg;
      sfsp_pkg::SFSP_SF_HOLD:    target_speed = speed_reg;
      sfsp_pkg::SFSP_LEVEL:      target_speed = leveling_speed;
      sfsp_pkg::SFSP_STOP:       target_speed = '0;
    endcase
    reached = (speed_reg == target_speed);
  end

  // next state of the profile
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      sfsp_pkg::SFSP_IDLE:
        if (run_s)
          state_next = dwell_s ? sfsp_pkg::SFSP_DWELL : sfsp_pkg::SFSP_RUN;
      sfsp_pkg::SFSP_DWELL:
        if (reached)
          state_next = sfsp_pkg::SFSP_DWELL_HOLD;
      sfsp_pkg::SFSP_DWELL_HOLD:
        if (hold_cnt_reg == '0)
          state_next = sfsp_pkg::SFSP_RUN;
      sfsp_pkg::SFSP_RUN:
        if (lvl_req)
        begin
          // short floor only while still short of nominal
          if (sf_allowed && (speed_reg < nom_speed))
            state_next = sfsp_pkg::SFSP_SF_RAMP;
          else
            state_next = sfsp_pkg::SFSP_LEVEL;
        end
      sfsp_pkg::SFSP_SF_RAMP:
        if (prio_multi && !lvl_req)
          state_next = sfsp_pkg::SFSP_RUN;
        else if (reached)
          state_next = sfsp_pkg::SFSP_SF_HOLD;
      sfsp_pkg::SFSP_SF_HOLD:
        if (prio_multi && !lvl_req)
          state_next = sfsp_pkg::SFSP_RUN;
        else if (hold_cnt_reg == '0)
          state_next = sfsp_pkg::SFSP_LEVEL;
      sfsp_pkg::SFSP_LEVEL:
        state_next = state_reg;
      sfsp_pkg::SFSP_STOP:
        if (speed_reg == '0)
          state_next = sfsp_pkg::SFSP_IDLE;
    endcase
    // removing the run command always ends the profile with a stop ramp
    if (!run_s && (state_reg != sfsp_pkg::SFSP_IDLE) && (state_reg != sfsp_pkg::SFSP_STOP))
      state_next = sfsp_pkg::SFSP_STOP;
  end

  // state register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= sfsp_pkg::SFSP_IDLE;
    else
      state_reg <= state_next;
  end

  // start reference and short floor target, frozen at their events
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_ref_reg <= '0;
      sf_target_reg <= '0;
    end
    else
    begin
      if ((state_reg == sfsp_pkg::SFSP_IDLE) && run_s)
        start_ref_reg <= speed_ref;
      // computed once at the request so a moving speed cannot chase it
      if ((state_reg != sfsp_pkg::SFSP_SF_RAMP) && (state_next == sfsp_pkg::SFSP_SF_RAMP))
        sf_target_reg <= sf_target_calc;
    end
  end

  // hold timer in ms, loaded on entry to a hold state
  always_comb
  begin
    if (state_next == sfsp_pkg::SFSP_DWELL_HOLD)
      hold_load_val = 32'(dwell_time) * 32'(sfsp_pkg::MS_PER_HOLD_UNIT);
    else
      hold_load_val = 32'(min_constant_speed_time) * 32'(sfsp_pkg::MS_PER_HOLD_UNIT);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      hold_cnt_reg <= '0;
    else if ((state_next != state_reg) && ((state_next == sfsp_pkg::SFSP_SF_HOLD) ||
             (state_next == sfsp_pkg::SFSP_DWELL_HOLD)))
      hold_cnt_reg <= hold_load_val;
    else if (tick_ms && (hold_cnt_reg != '0))
      hold_cnt_reg <= hold_cnt_reg - 32'h0000_0001;
  end

  // distance gains; factory initialisation wins over a load in the same cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accel_gain_reg <= sfsp_pkg::GAIN_DEFAULT;
      decel_gain_reg <= sfsp_pkg::GAIN_DEFAULT;
    end
    else if (finit_s)
    begin
      accel_gain_reg <= sfsp_pkg::GAIN_DEFAULT;
      decel_gain_reg <= sfsp_pkg::GAIN_DEFAULT;
    end
    else if (gain_load)
    begin
      accel_gain_reg <= accel_distance_gain;
      decel_gain_reg <= decel_distance_gain;
    end
  end

  // 1 ms base for ramps and holds
  sfsp_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk  (mclk),
    .rst_b (rst_b),
    .tick  (tick_ms)
  );

  // ramp rate scaled to maximum output frequency over the selected time
  sfsp_ramp_step #(
    .SPD_W  (SPD_W),
    .TIME_W (TIME_W)
  ) u_ramp (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .tick_ms    (tick_ms),
    .speed_cur  (speed_reg),
    .speed_tgt  (target_speed),
    .max_freq   (max_output_frequency),
    .accel_time (accel_time),
    .decel_time (decel_time),
    .step_up    (step_up),
    .step_dn    (step_dn)
  );

  // output speed integrates the steps
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      speed_reg <= '0;
    else if (step_up && (speed_reg < target_speed))
      speed_reg <= speed_reg + 1'b1;
    else if (step_dn && (speed_reg > target_speed))
      speed_reg <= speed_reg - 1'b1;
  end

  // status flags, all registered
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      short_floor_active <= 1'b0;
      level_detect_used  <= 1'b0;
      hold_active        <= 1'b0;
    end
    else
    begin
      short_floor_active <= (state_next == sfsp_pkg::SFSP_SF_RAMP) ||
                            (state_next == sfsp_pkg::SFSP_SF_HOLD);
      level_detect_used  <= prio_multi &&
                            (short_floor_mode_sel != sfsp_pkg::MODE_OFF);
      hold_active        <= (state_next == sfsp_pkg::SFSP_SF_HOLD);
    end
  end

  assign speed_out         = speed_reg;
  assign accel_gain_active = accel_gain_reg;
  assign decel_gain_active = decel_gain_reg;
endmodule
`default_nettype wire

// file: rtl/sfsp_pkg.sv
// constants, codes and state encoding for the short floor speed profile block
// assumes speeds in 0.01 Hz, ramp times in 0.01 s, hold times in 0.1 s, gains in 0.1 %
package sfsp_pkg;

  // data widths
  localparam int SPD_W  = 16;
  localparam int TIME_W = 16;
  localparam int GAIN_W = 16;

  // factory value of both distance gains, 150.0 %
  localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 16'h05DC;
  // 100.0 % in gain units: no s-curve compensation
  localparam int GAIN_UNITY = 1000;

  // simple mode intermediate speed, percent of nominal
  localparam int PCT_SIMPLE = 40;
  localparam int PCT_FULL   = 100;

  // base tick of the ramp and hold timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // milliseconds per unit of a ramp time and of a hold time
  localparam int MS_PER_RAMP_UNIT = 10;
  localparam int MS_PER_HOLD_UNIT = 100;

  // short floor mode select codes
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SIMPLE = 2'h1;
  localparam logic [1:0] MODE_ADV    = 2'h2;

  // speed reference priority codes
  localparam logic [1:0] PRIO_MULTI_A = 2'h0;
  localparam logic [1:0] PRIO_MULTI_B = 2'h3;

  // synchroniser bundle layout
  localparam int SYN_RUN   = 0;
  localparam int SYN_LVL   = 1;
  localparam int SYN_SEL0  = 2;
  localparam int SYN_SEL1  = 3;
  localparam int SYN_RESC  = 4;
  localparam int SYN_INSP  = 5;
  localparam int SYN_FINIT = 6;
  localparam int SYN_DWELL = 7;
  localparam int SYN_W     = 8;

  // profile sequencer states, gray along idle-dwell-run-short floor-level-stop
  typedef enum logic [2:0] {
    SFSP_IDLE       = 3'h0,
    SFSP_DWELL      = 3'h1,
    SFSP_RUN        = 3'h3,
    SFSP_SF_RAMP    = 3'h2,
    SFSP_SF_HOLD    = 3'h6,
    SFSP_LEVEL      = 3'h7,
    SFSP_STOP       = 3'h5,
    SFSP_DWELL_HOLD = 3'h4
  } sfsp_state_e;

endpackage

// file: rtl/sfsp_ramp_step.sv
// ramp rate generator: one up or down step of one speed unit at the ramp rate
// assumes a 1 ms tick; a ramp time is full scale travel in 0.01 s units
`timescale 1ns/1ns
`default_nettype none
module sfsp_ramp_step #(
  parameter int SPD_W  = 16,
  parameter int TIME_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              tick_ms,
  input  wire logic [SPD_W-1:0]  speed_cur,
  input  wire logic [SPD_W-1:0]  speed_tgt,
  input  wire logic [SPD_W-1:0]  max_freq,
  input  wire logic [TIME_W-1:0] accel_time,
  input  wire logic [TIME_W-1:0] decel_time,
  output logic                   step_up,
  output logic                   step_dn
);
  logic [31:0] acc_reg;
  logic [31:0] denom;
  logic        go_up;
  logic        go_dn;

  // full scale over the ramp time: acc gains max_freq per ms, a step costs time in ms
  always_comb
  begin
    go_up = (speed_tgt > speed_cur);
    go_dn = (speed_tgt < speed_cur);
    denom = 32'(go_up ? accel_time : decel_time) * 32'(sfsp_pkg::MS_PER_RAMP_UNIT);
  end

  // one step every second clock at most; a zero time steps every second clock
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_reg <= '0;
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end
    else if (!(go_up || go_dn) || step_up || step_dn)
    begin
      acc_reg <= (go_up || go_dn) ? acc_reg : '0; // no leftover credit at a plateau
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end
    else if (tick_ms)
    begin
      acc_reg <= acc_reg + 32'(max_freq);
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end
    else if (acc_reg >= denom)
    begin
      acc_reg <= acc_reg - denom;
      step_up <= go_up;
      step_dn <= go_dn;
    end
    else
    begin
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sfsp_tick_div.sv
// divider giving a one-cycle enable pulse every CYCLES clocks
// assumes a free running clock and an asynchronous active low reset
`timescale 1ns/1ns
`default_nettype none
module sfsp_tick_div #(
  parameter int CYCLES = 25000
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES) + 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;

  // wrap counter, pulse on the last count
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= (cnt_reg == LAST);
      if (cnt_reg == LAST)
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verification/sfsp_core_asserts.sv
// port checker for the short floor speed profile sequencer
// assumes the default widths of sfsp_pkg and a bind onto sfsp_core
`timescale 1ns/1ns
`default_nettype none
module sfsp_core_asserts (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        factory_init,
  input wire logic        rescue_run,
  input wire logic        inspection_run,
  input wire logic        gain_load,
  input wire logic [1:0]  short_floor_mode_sel,
  input wire logic [1:0]  speed_ref_priority_sel,
  input wire logic [15:0] nominal_speed_setting,
  input wire logic [15:0] accel_distance_gain,
  input wire logic [15:0] speed_out,
  input wire logic        short_floor_active,
  input wire logic        level_detect_used,
  input wire logic        hold_active,
  input wire logic [15:0] accel_gain_active,
  input wire logic [15:0] decel_gain_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // four clocks cover the two-flop sync plus the register
  sequence s_init_held;
    factory_init [*4];
  endsequence
  sequence s_load_clean;
    (!factory_init) [*4] ##0 gain_load;
  endsequence
  // multi-speed priority codes
  wire logic prio_multi = speed_ref_priority_sel == 2'h0 || speed_ref_priority_sel == 2'h3;

  a_speed_step: assert property (
    speed_out == $past(speed_out) || speed_out == $past(speed_out) + 16'h0001 ||
    speed_out + 16'h0001 == $past(speed_out)) else $error("speed_out jumped");
  a_mode_off: assert property (
    (short_floor_mode_sel == 2'h0) [*3] |-> !short_floor_active) else $error("sf when off");
  a_detect_on: assert property (
    (short_floor_mode_sel != 2'h0 && prio_multi) [*3] |-> level_detect_used)
    else $error("detection not used");
  a_detect_off: assert property (
    (!prio_multi) [*3] |-> !level_detect_used) else $error("detection used");
  a_hold_steady: assert property (
    hold_active [*2] |-> $stable(speed_out)) else $error("speed moved in hold");
  a_no_adv_rescue: assert property (
    (short_floor_mode_sel == 2'h2 && (rescue_run || inspection_run)) [*4]
    |-> !$rose(short_floor_active)) else $error("advanced sf in rescue");
  a_sf_below_nom: assert property (
    $rose(short_floor_active) && short_floor_mode_sel == 2'h1 && !prio_multi
    |-> speed_out <= nominal_speed_setting) else $error("sf above nominal");
  a_gain_load: assert property (
    s_load_clean |=> accel_gain_active == $past(accel_distance_gain))
    else $error("gain not loaded");
  a_gain_factory: assert property (
    s_init_held |-> accel_gain_active == 16'h05DC && decel_gain_active == 16'h05DC)
    else $error("gains not at factory value");
endmodule
bind sfsp_core sfsp_core_asserts chk_u (.mclk(mclk), .rst_b(rst_b),
  .factory_init(factory_init), .rescue_run(rescue_run), .inspection_run(inspection_run),
  .gain_load(gain_load), .short_floor_mode_sel(short_floor_mode_sel),
  .speed_ref_priority_sel(speed_ref_priority_sel),
  .nominal_speed_setting(nominal_speed_setting), .accel_distance_gain(accel_distance_gain),
  .speed_out(speed_out), .short_floor_active(short_floor_active),
  .level_detect_used(level_detect_used), .hold_active(hold_active),
  .accel_gain_active(accel_gain_active), .decel_gain_active(decel_gain_active));
`default_nettype wire

// file: verification/sfsp_lift_ctl.sv
// lift controller model: run, leveling at a floor speed, then stop
// assumes the block treats these as asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module sfsp_lift_ctl (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic        stop,
  input  wire logic        early_rel,
  input  wire logic [15:0] lvl_at,
  input  wire logic [15:0] speed_out,
  output logic             run_cmd,
  output logic             leveling_cmd
);
  initial
  begin
    run_cmd = 1'b0;
    leveling_cmd = 1'b0;
  end
  // leveling only once moving, like a controller nearing the floor
  always @(posedge go)
  begin
    run_cmd = 1'b1;
    wait (speed_out == lvl_at);
    @(posedge mclk);
    #2 leveling_cmd = 1'b1;
    if (early_rel)
    begin
      repeat (300) @(posedge mclk);
      #2 leveling_cmd = 1'b0;
    end
  end
  // run drops first; leveling follows a clock later
  always @(posedge stop)
  begin
    run_cmd = 1'b0;
    @(posedge mclk);
    #2 leveling_cmd = 1'b0;
  end
endmodule
`default_nettype wire

// file: verification/test_short_floor_speed_profile.sv
// self-checking bench for the short floor speed profile sequencer
// assumes the controller model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 5000) begin @(posedge mclk); #2; n++; end \
  if (n >= 5000) `CHK("wait", 1'b0, 1'b1) end
module test_short_floor_speed_profile;
  logic        mclk, rst_b, go, stop, early, resc, insp, fini, gload, dwell;
  logic        run_cmd, leveling_cmd, sfa, det, hold;
  logic [1:0]  mode, prio, sel;
  logic [15:0] sref, lvl_at, gain, speed_out, ag, dg, cv [12];
  int          err_count, samples_checked, n;
  bit          sf_seen;

  // short tick keeps ramps and holds to a few hundred clocks
  sfsp_core #(.TICK_CYCLES(4)) dut_u (.mclk(mclk), .rst_b(rst_b), .run_cmd(run_cmd),
    .leveling_cmd(leveling_cmd), .accel_decel_sel(sel), .rescue_run(resc),
    .inspection_run(insp), .factory_init(fini), .dwell_enable(dwell),
    .short_floor_mode_sel(mode), .speed_ref_priority_sel(prio), .speed_ref(sref),
    .leveling_speed(cv[0]), .nominal_speed_setting(cv[1]),
    .short_floor_nominal_speed(cv[2]), .level_speed_detect_threshold(cv[3]),
    .max_output_frequency(cv[4]), .min_constant_speed_time(cv[5]),
    .gain_load(gload), .accel_distance_gain(gain), .decel_distance_gain(gain),
    .accel_time_1(cv[6]), .decel_time_1(cv[7]), .accel_time_2(16'h0014),
    .decel_time_2(16'h0014), .accel_time_3(16'h001E), .decel_time_3(16'h001E),
    .accel_time_4(cv[8]), .decel_time_4(cv[9]), .decel_switch_freq(cv[10]),
    .dwell_speed(16'h0005), .dwell_time(cv[11]), .speed_out(speed_out),
    .short_floor_active(sfa), .level_detect_used(det), .hold_active(hold),
    .accel_gain_active(ag), .decel_gain_active(dg));

  sfsp_lift_ctl ctl_u (.mclk(mclk), .go(go), .stop(stop), .early_rel(early), .lvl_at(lvl_at),
    .speed_out(speed_out), .run_cmd(run_cmd), .leveling_cmd(leveling_cmd));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // remember any short floor phase within a case
  always @(posedge mclk)
    if (sfa === 1'b1)
      sf_seen <= 1'b1;

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one run: sf means a short floor hold at speed e; rel means release and return to e
  task automatic run_case(input logic [1:0] m, input logic [1:0] p, input logic [15:0] r,
    input logic [15:0] a, input bit rel, input bit sf, input logic [15:0] e);
    mode = m;
    prio = p;
    sref = r;
    lvl_at = a;
    early = rel;
    sf_seen = 1'b0;
    sel = sel + 2'h1;
    repeat (4) @(posedge mclk);
    #2 go = 1'b1;
    `WAITC(leveling_cmd === 1'b1)
    if (rel)
    begin
      `WAITC(speed_out === e)
      `CHK("sf after release", sfa, 1'b0)
      `CHK("sf seen", sf_seen, 1'b1)
    end
    else if (sf)
    begin
      `WAITC(hold === 1'b1)
      `CHK("hold speed", speed_out, e)
      `WAITC(speed_out === 16'h000A)
    end
    else
    begin
      `WAITC(speed_out === 16'h000A)
      `CHK("sf seen", sf_seen, 1'b0)
    end
    `CHK("detect used", det, (m != 2'h0) && (p == 2'h0 || p == 2'h3))
    stop = 1'b1;
    `WAITC(speed_out === 16'h0000 && run_cmd === 1'b0)
    go = 1'b0;
    stop = 1'b0;
    dwell = 1'b0;
    $display("case done mode %0d prio %0d ref %0h", m, p, r);
  endtask

  // watchdog, well past the expected length of the run
  initial
  begin
    #3000000;
    err_count++;
    close_out;
  end

  initial
  begin
    {rst_b, go, stop, early, resc, insp, fini, gload, dwell} = '0;
    {mode, prio, sel} = '0;
    sref = 16'h0064;
    lvl_at = 16'h0014;
    gain = 16'h07D0;
    cv = '{16'h000A, 16'h0064, 16'h00C8, 16'h0000, 16'h1388, 16'h0001, 16'h000A,
           16'h000A, 16'h0028, 16'h0028, 16'h0014, 16'h0001};
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge mclk);
    #2 rst_b = 1'b1;
    `CHK("gain at reset", ag, sfsp_pkg::GAIN_DEFAULT)
    repeat (4) @(posedge mclk);
    #2 gload = 1'b1;
    @(posedge mclk);
    #2 `CHK("gain loaded", dg, 16'h07D0)
    fini = 1'b1; // load held high: init must win
    repeat (6) @(posedge mclk);
    #2 `CHK("gain after init", dg, sfsp_pkg::GAIN_DEFAULT)
    fini = 1'b0;
    repeat (4) @(posedge mclk);
    #2 gload = 1'b0;
    `CHK("gain reloaded", ag, 16'h07D0)
    $display("gain test done");
    run_case(2'h1, 2'h1, 16'h0064, 16'h003C, 0, 1, 16'h0028);
    dwell = 1'b1;
    run_case(2'h1, 2'h1, 16'h0064, 16'h0014, 0, 1, 16'h0028);
    run_case(2'h1, 2'h1, 16'h001E, 16'h001E, 0, 1, 16'h001E);
    run_case(2'h1, 2'h1, 16'h0050, 16'h0050, 0, 1, 16'h0028);
    run_case(2'h1, 2'h0, 16'h0096, 16'h0064, 0, 1, 16'h0050);
    run_case(2'h2, 2'h1, 16'h0064, 16'h0014, 0, 1, 16'h0032);
    run_case(2'h2, 2'h1, 16'h0046, 16'h0046, 0, 1, 16'h0046);
    cv[3] = 16'h0050; // leveling by threshold, before the pin
    run_case(2'h2, 2'h3, 16'h0050, 16'h0028, 0, 1, 16'h0028);
    run_case(2'h1, 2'h3, 16'h0096, 16'h001E, 1, 1, 16'h0096);
    resc = 1'b1;
    run_case(2'h2, 2'h1, 16'h0064, 16'h0014, 0, 0, 16'h000A);
    resc = 1'b0;
    insp = 1'b1;
    run_case(2'h2, 2'h1, 16'h0064, 16'h0014, 0, 0, 16'h000A);
    insp = 1'b0;
    run_case(2'h0, 2'h1, 16'h0064, 16'h0014, 0, 0, 16'h000A);
    close_out;
  end
endmodule
`default_nettype wire
